// ### dee_access_top.sv
// Purpose: APB register front end and write control of the data EEPROM
// Assumes: rst is the power-on reset, warm_reset an external or watchdog reset
// Notes: Zero wait states, every transfer answers in its first access cycle
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dee_defines.svh"
module dee_access_top #(
	parameter int POWERUP_CYCLES = `DEE_POWERUP_MS * `DEE_CLK_KHZ,
	parameter int WRITE_CYCLES = `DEE_WRITE_US * `DEE_CLK_MHZ
) (
	// System
	input wire logic clk,
	input wire logic rst,
	input wire logic warm_reset,
	input wire logic data_protect_fuse,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`DEE_PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Status
	output logic write_done_flag,
	output logic prog_access_ok
);
	logic wr_acc;
	logic setup_rd;
	logic mapped;
	logic flags_wr;
	logic data_wr;
	logic addr_wr;
	logic ctrl_wr;
	logic unlock_wr;
	logic rd_start;
	logic seq_start;
	logic wr_start;
	logic wr_end;
	logic rd_pend;
	logic wr_bit;
	logic permit;
	logic abort_flag;
	logic powerup_done;
	logic [31:0] powerup_cnt;
	logic [31:0] wcnt;
	logic [7:0] data_reg;
	logic [6:0] addr_reg;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] mem_rdata;
	logic [31:0] next_prdata;

	function automatic logic dee_hit(input logic [`DEE_PADDR_W-1:0] a, input logic [7:0] idx);
		dee_hit = (a == {2'b00, idx, 2'b00});
	endfunction

	assign mapped = dee_hit(paddr, `DEE_IDX_FLAGS) || dee_hit(paddr, `DEE_IDX_DATA)
		|| dee_hit(paddr, `DEE_IDX_ADDR) || dee_hit(paddr, `DEE_IDX_CTRL)
		|| dee_hit(paddr, `DEE_IDX_UNLOCK);

	// A write takes effect only at the edge that completes the transfer
	assign wr_acc = psel && penable && pready && pwrite && !pslverr;
	assign setup_rd = psel && !penable && !pwrite;
	assign flags_wr = wr_acc && dee_hit(paddr, `DEE_IDX_FLAGS);
	assign data_wr = wr_acc && dee_hit(paddr, `DEE_IDX_DATA);
	assign addr_wr = wr_acc && dee_hit(paddr, `DEE_IDX_ADDR);
	assign ctrl_wr = wr_acc && dee_hit(paddr, `DEE_IDX_CTRL);
	assign unlock_wr = wr_acc && dee_hit(paddr, `DEE_IDX_UNLOCK);

	assign rd_start = ctrl_wr && pwdata[`DEE_CTRL_RD] && !rd_pend && !warm_reset;
	// Old permit value gates the trigger, so one write cannot both enable and start
	assign wr_start = seq_start && permit && powerup_done && !wr_bit && !warm_reset;
	assign wr_end = wr_bit && (wcnt == 32'(WRITE_CYCLES - 1)) && !warm_reset;

	dee_unlock u_unlock (
		.clk(clk),
		.rst(rst),
		.clear(warm_reset),
		.any_wr(wr_acc),
		.key_wr(unlock_wr),
		.key(pwdata[7:0]),
		.trig_wr(ctrl_wr && pwdata[`DEE_CTRL_WR]),
		.start(seq_start)
	);

	// Write uses the address and data latched at start
	dee_mem u_mem (
		.clk(clk),
		.we(wr_end),
		.waddr(wr_addr),
		.wdata(wr_data),
		.re(rd_start),
		.raddr(addr_reg),
		.rdata(mem_rdata)
	);

	// Read mux; bypass covers a read right after the trigger
	always_comb begin
		next_prdata = 32'h0;
		if (dee_hit(paddr, `DEE_IDX_FLAGS)) begin
			next_prdata[`DEE_FLAGS_DONE] = write_done_flag;
		end
		if (dee_hit(paddr, `DEE_IDX_DATA)) begin
			next_prdata[7:0] = rd_pend ? mem_rdata : data_reg;
		end
		if (dee_hit(paddr, `DEE_IDX_ADDR)) begin
			next_prdata[6:0] = addr_reg;
		end
		if (dee_hit(paddr, `DEE_IDX_CTRL)) begin
			next_prdata[`DEE_CTRL_RD] = rd_pend;
			next_prdata[`DEE_CTRL_WR] = wr_bit;
			next_prdata[`DEE_CTRL_PERMIT] = permit;
			next_prdata[`DEE_CTRL_ABORT] = abort_flag;
		end
		// Unlock index falls through as all zero
	end

	// Bus answer, registered so outputs come from flops
	always_ff @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= setup_rd ? next_prdata : 32'h0;
		end
	end

	// Power-up timer, started only by the power-on reset
	always_ff @(posedge clk) begin
		if (rst) begin
			powerup_cnt <= 32'h0;
			powerup_done <= 1'b0;
		end else if (!powerup_done) begin
			powerup_cnt <= powerup_cnt + 32'h1;
			powerup_done <= (powerup_cnt >= 32'(POWERUP_CYCLES - 1));
		end
	end

	always_ff @(posedge clk) begin
		if (rst || warm_reset) begin
			data_reg <= `DEE_BYTE_RST;
		end else if (rd_pend) begin
			data_reg <= mem_rdata;
		end else if (data_wr) begin
			data_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst || warm_reset) begin
			addr_reg <= `DEE_ADDR_RST;
		end else if (addr_wr) begin
			addr_reg <= pwdata[6:0];
		end
	end

	// Read trigger lives one cycle; software writes of zero do nothing
	always_ff @(posedge clk) begin
		if (rst || warm_reset) begin
			rd_pend <= 1'b0;
		end else begin
			rd_pend <= rd_start;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || warm_reset) begin
			permit <= 1'b0;
		end else if (ctrl_wr) begin
			permit <= pwdata[`DEE_CTRL_PERMIT];
		end
	end

	// Abort set wins over a software clear
	always_ff @(posedge clk) begin
		if (rst) begin
			abort_flag <= 1'b0;
		end else if (warm_reset && wr_bit) begin
			abort_flag <= 1'b1;
		end else if (ctrl_wr) begin
			abort_flag <= pwdata[`DEE_CTRL_ABORT];
		end
	end

	// Self-timed write; permit is not looked at once running
	always_ff @(posedge clk) begin
		if (rst || warm_reset) begin
			wr_bit <= 1'b0;
			wcnt <= 32'h0;
		end else if (wr_start) begin
			wr_bit <= 1'b1;
			wcnt <= 32'h0;
		end else if (wr_end) begin
			wr_bit <= 1'b0;
		end else if (wr_bit) begin
			wcnt <= wcnt + 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_addr <= `DEE_ADDR_RST;
			wr_data <= `DEE_BYTE_RST;
		end else if (wr_start) begin
			wr_addr <= addr_reg;
			wr_data <= data_reg;
		end
	end

	// Completion set wins over a software clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst || warm_reset) begin
			write_done_flag <= 1'b0;
		end else if (wr_end) begin
			write_done_flag <= 1'b1;
		end else if (flags_wr) begin
			write_done_flag <= pwdata[`DEE_FLAGS_DONE];
		end
	end

	// Fuse only closes the programmer path; CPU access is untouched
	always_ff @(posedge clk) begin
		if (rst) begin
			prog_access_ok <= 1'b0;
		end else begin
			prog_access_ok <= data_protect_fuse;
		end
	end

	property p_read_next;
		@(posedge clk) disable iff (rst)
		rd_start ##1 !warm_reset |=> data_reg == $past(mem_rdata);
	endproperty
	a_read_next: assert property (p_read_next) else $error("read byte not loaded next cycle");

	property p_data_hold;
		@(posedge clk) disable iff (rst)
		!rd_pend && !data_wr && !warm_reset |=> $stable(data_reg);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data register changed on its own");

	property p_start_gate;
		@(posedge clk) disable iff (rst)
		$rose(wr_bit) |-> $past(permit) && $past(powerup_done) && $past(seq_start);
	endproperty
	a_start_gate: assert property (p_start_gate) else $error("write started while not allowed");

	property p_permit_kept;
		@(posedge clk) disable iff (rst)
		permit && !ctrl_wr && !warm_reset |=> permit;
	endproperty
	a_permit_kept: assert property (p_permit_kept) else $error("permit cleared by hardware");

	property p_write_runs;
		@(posedge clk) disable iff (rst)
		$fell(wr_bit) && !$past(warm_reset) |-> $past(wcnt) == 32'(WRITE_CYCLES - 1);
	endproperty
	a_write_runs: assert property (p_write_runs) else $error("write ended early");

	property p_done_set;
		@(posedge clk) disable iff (rst)
		wr_end |=> !wr_bit && write_done_flag;
	endproperty
	a_done_set: assert property (p_done_set) else $error("write end did not flag done");

	property p_done_hold;
		@(posedge clk) disable iff (rst)
		write_done_flag && !flags_wr && !warm_reset |=> write_done_flag;
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("done flag dropped by itself");

	property p_powerup_block;
		@(posedge clk) disable iff (rst)
		!powerup_done |-> !wr_start ##1 !wr_bit;
	endproperty
	a_powerup_block: assert property (p_powerup_block) else $error("write during power-up delay");

	property p_trig_clear;
		@(posedge clk) disable iff (rst)
		wr_bit && !wr_end && !warm_reset |=> wr_bit;
	endproperty
	a_trig_clear: assert property (p_trig_clear) else $error("write trigger cleared early");

	property p_abort;
		@(posedge clk) disable iff (rst)
		warm_reset && wr_bit |=> abort_flag && !wr_bit;
	endproperty
	a_abort: assert property (p_abort) else $error("abort not flagged");

	property p_addr_msb;
		@(posedge clk) disable iff (rst)
		setup_rd && dee_hit(paddr, `DEE_IDX_ADDR) |=> prdata[7] == 1'b0;
	endproperty
	a_addr_msb: assert property (p_addr_msb) else $error("address bit 7 not ignored");

	property p_unlock_zero;
		@(posedge clk) disable iff (rst)
		setup_rd && dee_hit(paddr, `DEE_IDX_UNLOCK) |=> prdata == 32'h0 && pready;
	endproperty
	a_unlock_zero: assert property (p_unlock_zero) else $error("unlock register read nonzero");

	property p_rd_clear;
		@(posedge clk) disable iff (rst)
		rd_pend |=> !rd_pend;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("read trigger not cleared by hardware");

	property p_unlock_nostore;
		@(posedge clk) disable iff (rst)
		unlock_wr && !warm_reset |=> $stable(addr_reg) && $stable(permit);
	endproperty
	a_unlock_nostore: assert property (p_unlock_nostore) else $error("unlock write stored a value");

	property p_permit_power;
		@(posedge clk)
		rst |=> !permit;
	endproperty
	a_permit_power: assert property (p_permit_power) else $error("permit set after power-up");

	property p_fuse_follow;
		@(posedge clk) disable iff (rst)
		!$past(rst) |-> prog_access_ok == $past(data_protect_fuse);
	endproperty
	a_fuse_follow: assert property (p_fuse_follow) else $error("fuse level not followed");

	property p_latch_target;
		@(posedge clk) disable iff (rst)
		wr_start |=> wr_addr == $past(addr_reg) && wr_data == $past(data_reg);
	endproperty
	a_latch_target: assert property (p_latch_target) else $error("write target not latched");

	property p_done_clear;
		@(posedge clk) disable iff (rst)
		flags_wr && !pwdata[`DEE_FLAGS_DONE] && !wr_end |=> !write_done_flag;
	endproperty
	a_done_clear: assert property (p_done_clear) else $error("done flag not cleared by software");

	property p_count_restart;
		@(posedge clk) disable iff (rst)
		$rose(wr_bit) |-> wcnt == 32'h0;
	endproperty
	a_count_restart: assert property (p_count_restart) else $error("write counter not restarted");
endmodule
`default_nettype wire

// ### dee_defines.svh
// Purpose: Constants for the data EEPROM access block
// Assumes: 20 MHz clock, APB register indices times four give byte addresses
// Notes: Types live in dee_pkg
`ifndef DEE_DEFINES_SVH
`define DEE_DEFINES_SVH

`define DEE_PADDR_W 12
`define DEE_IDX_FLAGS 8'h0c
`define DEE_IDX_DATA 8'h9a
`define DEE_IDX_ADDR 8'h9b
`define DEE_IDX_CTRL 8'h9c
`define DEE_IDX_UNLOCK 8'h9d
`define DEE_KEY_FIRST 8'h55
`define DEE_KEY_SECOND 8'haa
`define DEE_CTRL_RD 0
`define DEE_CTRL_WR 1
`define DEE_CTRL_PERMIT 2
`define DEE_CTRL_ABORT 3
`define DEE_FLAGS_DONE 7
`define DEE_BYTE_RST 8'h00
`define DEE_ADDR_RST 7'h00
`define DEE_MEM_DEPTH 128
`define DEE_SEQ_GAP_CYC 4'h2
`define DEE_CLK_KHZ 20000
`define DEE_CLK_MHZ 20
`define DEE_POWERUP_MS 72
`define DEE_WRITE_US 5

`endif

// ### dee_pkg.sv
// Purpose: Shared types of the data EEPROM access block
// Assumes: Nothing beyond the defines header
// Notes: Unlock sequence states only
`default_nettype none
package dee_pkg;
	typedef enum logic [1:0] {
		DEE_SEQ_IDLE = 2'b00,
		DEE_SEQ_GOT_FIRST = 2'b01,
		DEE_SEQ_GOT_SECOND = 2'b10
	} dee_seq_t;
endpackage
`default_nettype wire

// ### dee_mem.sv
// Purpose: 128 x 8 data array with registered read
// Assumes: One write and one read port
// Notes: Array has no reset, like real cells
`timescale 1ns/1ps
`default_nettype none
`include "dee_defines.svh"
module dee_mem (
	// Clock
	input wire logic clk,
	// Write port
	input wire logic we,
	input wire logic [6:0] waddr,
	input wire logic [7:0] wdata,
	// Read port
	input wire logic re,
	input wire logic [6:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] cells [0:`DEE_MEM_DEPTH-1];

	always_ff @(posedge clk) begin
		if (we) begin
			cells[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (re) begin
			rdata <= cells[raddr];
		end
	end
endmodule
`default_nettype wire

// ### dee_unlock.sv
// Purpose: Unlock sequence tracker with exact cycle spacing
// Assumes: any_wr pulses once per completed bus write
// Notes: Any other write between steps restarts the sequence
`timescale 1ns/1ps
`default_nettype none
`include "dee_defines.svh"
module dee_unlock (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	// Completed bus writes
	input wire logic any_wr,
	input wire logic key_wr,
	input wire logic [7:0] key,
	input wire logic trig_wr,
	// Sequence result
	output logic start
);
	dee_pkg::dee_seq_t state, next_state;
	logic [3:0] gap;
	logic gap_ok;

	assign gap_ok = (gap == `DEE_SEQ_GAP_CYC - 4'h1);
	assign start = (state == dee_pkg::DEE_SEQ_GOT_SECOND) && any_wr && trig_wr && gap_ok;

	// Key writes decode only, nothing is stored
	always_comb begin
		next_state = state;
		if (any_wr) begin
			unique case (state)
				dee_pkg::DEE_SEQ_GOT_FIRST: begin
					if (key_wr && key == `DEE_KEY_SECOND && gap_ok) begin
						next_state = dee_pkg::DEE_SEQ_GOT_SECOND;
					end else if (key_wr && key == `DEE_KEY_FIRST) begin
						next_state = dee_pkg::DEE_SEQ_GOT_FIRST;
					end else begin
						next_state = dee_pkg::DEE_SEQ_IDLE;
					end
				end
				dee_pkg::DEE_SEQ_IDLE, dee_pkg::DEE_SEQ_GOT_SECOND: begin
					if (key_wr && key == `DEE_KEY_FIRST) begin
						next_state = dee_pkg::DEE_SEQ_GOT_FIRST;
					end else begin
						next_state = dee_pkg::DEE_SEQ_IDLE;
					end
				end
				default: next_state = dee_pkg::DEE_SEQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst || clear) begin
			state <= dee_pkg::DEE_SEQ_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Cycles since the last completed write, saturating
	always_ff @(posedge clk) begin
		if (rst || clear || any_wr) begin
			gap <= 4'h0;
		end else if (gap != 4'hf) begin
			gap <= gap + 4'h1;
		end
	end

	property p_seq_order;
		@(posedge clk) disable iff (rst)
		start |-> $past(key_wr, 2) && $past(key, 2) == `DEE_KEY_SECOND
			&& $past(key_wr, 4) && $past(key, 4) == `DEE_KEY_FIRST;
	endproperty
	a_seq_order: assert property (p_seq_order) else $error("start without exact unlock order");

	property p_seq_gap;
		@(posedge clk) disable iff (rst)
		start |-> !$past(any_wr, 1) && !$past(any_wr, 3);
	endproperty
	a_seq_gap: assert property (p_seq_gap) else $error("start with wrong step spacing");
endmodule
`default_nettype wire

// ### data_eeprom_access_control_tb.sv
// Purpose: Self-checking bench of the data EEPROM access block
// Assumes: Zero-wait APB slave, shortened power-up and write counts
// Notes: Random addresses and data come from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "dee_defines.svh"
module data_eeprom_access_control_tb;
	localparam int powerup_cyc = 60;
	localparam int wcyc = 12;
	localparam logic [11:0] a_flg = {2'b00, `DEE_IDX_FLAGS, 2'b00};
	localparam logic [11:0] a_dat = {2'b00, `DEE_IDX_DATA, 2'b00};
	localparam logic [11:0] a_adr = {2'b00, `DEE_IDX_ADDR, 2'b00};
	localparam logic [11:0] a_ctl = {2'b00, `DEE_IDX_CTRL, 2'b00};
	localparam logic [11:0] a_unl = {2'b00, `DEE_IDX_UNLOCK, 2'b00};
	logic clk, rst, warm_reset, data_protect_fuse, psel, penable, pwrite;
	logic [`DEE_PADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic pready, pslverr, write_done_flag, prog_access_ok, slv;
	int error_cnt, n_checks;
	logic [7:0] mem [128];
	bit wrote [128];

	dee_access_top #(.POWERUP_CYCLES(powerup_cyc), .WRITE_CYCLES(wcyc)) dut_u (
		.clk(clk), .rst(rst), .warm_reset(warm_reset), .data_protect_fuse(data_protect_fuse),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.write_done_flag(write_done_flag), .prog_access_ok(prog_access_ok)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic summarize();
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tdone(input string s);
		$display("test %s done, errors %0d", s, error_cnt);
	endtask

	function automatic logic [31:0] ctrl_exp(input logic wr, input logic pm, input logic ab);
		return {28'h0, ab, pm, wr, 1'b0};
	endfunction

	// Without last the bus stays selected so the next setup follows at once
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, input logic last);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'($urandom()), d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) chk(32'h0, 32'h1);
		rdat = prdata;
		slv = pslverr;
		if (last) begin
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'b1, a, d, 1'b1);
	endtask

	task automatic rd(input logic [11:0] a);
		xfer(1'b0, a, 8'h00, 1'b1);
	endtask

	// Keys and trigger back to back; gap inserts an idle cycle
	task automatic start_wr(input logic [7:0] k1, input logic [7:0] k2, input logic gap);
		xfer(1'b1, a_unl, k1, 1'b0);
		xfer(1'b1, a_unl, k2, gap);
		xfer(1'b1, a_ctl, 8'h06, 1'b1);
	endtask

	task automatic wait_done();
		int n;
		n = 0;
		while (write_done_flag !== 1'b1 && n < wcyc + 6) begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic readback(input logic [7:0] a, input logic [7:0] exp);
		wr(a_adr, a);
		// Data read right behind the trigger takes the bypass path
		xfer(1'b1, a_ctl, 8'h01, 1'b0);
		rd(a_dat);
		chk(rdat, {24'h0, exp});
	endtask

	// Whole run needs about six hundred cycles
	initial begin
		repeat (6000) @(posedge clk);
		error_cnt++;
		summarize();
	end

	initial begin
		logic [7:0] a, d, va;
		int m;
		rst = 1'b1;
		warm_reset = 1'b0;
		data_protect_fuse = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		error_cnt = 0;
		n_checks = 0;
		va = 8'h00;
		void'($urandom(32'h1c6f));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(a_ctl);
		chk(rdat & 32'h7, 32'h0);
		rd(a_dat);
		chk(rdat, 32'h0);
		rd(a_adr);
		chk(rdat, 32'h0);
		rd(a_flg);
		chk(rdat, 32'h0);
		rd(a_unl);
		chk(rdat, 32'h0);
		rd(12'h004);
		chk({rdat[30:0], slv}, 32'h1);
		wr(a_adr, 8'h05);
		wr(a_dat, 8'h3c);
		wr(a_ctl, 8'h04);
		start_wr(`DEE_KEY_FIRST, `DEE_KEY_SECOND, 1'b0);
		wait_done();
		chk(write_done_flag, 32'h0);
		rd(a_ctl);
		chk(rdat, ctrl_exp(1'b0, 1'b1, 1'b0));
		tdone("powerup");
		repeat (powerup_cyc) @(posedge clk);
		// Modes: 0 valid, 1 keys swapped, 2 idle gap, 3 permit clear beforehand
		for (int i = 0; i < 8; i++) begin
			m = i % 4;
			a = (i == 4) ? 8'hff : 8'($urandom());
			d = 8'($urandom());
			data_protect_fuse <= 1'($urandom());
			wr(a_adr, a);
			wr(a_dat, d);
			wr(a_ctl, (m == 3) ? 8'h00 : 8'h04);
			start_wr(m == 1 ? `DEE_KEY_SECOND : `DEE_KEY_FIRST,
				m == 1 ? `DEE_KEY_FIRST : `DEE_KEY_SECOND, m == 2);
			wr(a_ctl, (i < 4) ? 8'h00 : 8'h04);
			rd(a_ctl);
			chk(rdat, ctrl_exp(m == 0, i >= 4, 1'b0));
			wait_done();
			chk(write_done_flag, {31'h0, m == 0});
			rd(a_ctl);
			chk(rdat, ctrl_exp(1'b0, i >= 4, 1'b0));
			rd(a_flg);
			chk(rdat, {24'h0, m == 0, 7'h0});
			wr(a_flg, 8'h00);
			chk(write_done_flag, 32'h0);
			if (m == 0) begin
				mem[a[6:0]] = d;
				wrote[a[6:0]] = 1'b1;
				va = a;
			end
			if (wrote[a[6:0]]) begin
				readback(a ^ 8'h80, mem[a[6:0]]);
				rd(a_adr);
				chk(rdat, {25'h0, a[6:0]});
				rd(a_dat);
				chk(rdat, {24'h0, mem[a[6:0]]});
			end
			tdone("write");
		end
		// Reset in mid-write loses the byte and leaves the abort flag
		wr(a_adr, va);
		wr(a_dat, ~mem[va[6:0]]);
		wr(a_ctl, 8'h04);
		start_wr(`DEE_KEY_FIRST, `DEE_KEY_SECOND, 1'b0);
		repeat (3) @(posedge clk);
		warm_reset <= 1'b1;
		@(posedge clk);
		warm_reset <= 1'b0;
		@(posedge clk);
		rd(a_ctl);
		chk(rdat, ctrl_exp(1'b0, 1'b0, 1'b1));
		rd(a_dat);
		chk(rdat, 32'h0);
		rd(a_adr);
		chk(rdat, 32'h0);
		readback(va, mem[va[6:0]]);
		chk(write_done_flag, 32'h0);
		wr(a_ctl, 8'h00);
		rd(a_ctl);
		chk(rdat, 32'h0);
		tdone("abort");
		data_protect_fuse <= 1'b0;
		repeat (2) @(posedge clk);
		chk(prog_access_ok, 32'h0);
		data_protect_fuse <= 1'b1;
		repeat (2) @(posedge clk);
		chk(prog_access_ok, 32'h1);
		tdone("fuse");
		summarize();
	end
endmodule
`default_nettype wire
